// ### shared/cfg_pkg.sv
`default_nettype none
package cfg_pkg;
  // mode codes taken from the three mode pins
  localparam logic [2:0] MODE_SLAVE_SPI = 3'h0;
  localparam logic [2:0] MODE_MASTER_SPI = 3'h1;
  localparam logic [2:0] MODE_PARALLEL = 3'h2;
  localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h3;
  localparam logic [2:0] MODE_BURST_FLASH = 3'h4;
  // port lock codes
  localparam logic [1:0] PORT_NONE = 2'h0;
  localparam logic [1:0] PORT_PINS = 2'h1;
  localparam logic [1:0] PORT_JTAG = 2'h2;
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CLEAR_TIME_NS = 1000;
  localparam int CLEAR_CYCLES =
    (CLEAR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MCLK_HALF_CYCLES = 4;
  localparam int LOAD_BYTES = 16;
  localparam int FIFO_DEPTH = 4;
  // boundary-scan instruction codes, values arbitrary
  localparam logic [7:0] IR_CFG_LOAD = 8'h3A;
  localparam logic [7:0] IR_BYPASS = 8'hFF;
  localparam logic [7:0] IR_CAPTURE = 8'h01;
  // header sent to the serial flash before reading
  localparam logic [31:0] FLASH_READ_HDR = 32'h0300_0000;
  localparam logic [5:0] FLASH_HDR_BITS = 6'h20;
  typedef enum logic [1:0] {
    ST_CLEAR = 2'b00,
    ST_WAIT_READY = 2'b01,
    ST_LOAD = 2'b10,
    ST_DONE = 2'b11
  } cfg_state_e;
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3, TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5,
    TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7, TAP_UP_DR = 4'h8,
    TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR = 4'hB,
    TAP_EX1_IR = 4'hC, TAP_PA_IR = 4'hD, TAP_EX2_IR = 4'hE,
    TAP_UP_IR = 4'hF
  } tap_state_e;
endpackage : cfg_pkg
`default_nettype wire

// ### hdl/config_port_pin_control.sv
// Behaviour
// - mode pins captured at ready rising edge
// - program request low starts configuration
// - ready pin released when ready for data
// - done pin released when configuration complete
// - first used port locked until power-up
// - scan port loads only after command
// - scan state machine follows standard TAP
// - device drives master clock in master modes
// - busy pin: parallel busy, master serial out
// - select pin: chip select or flash enable
// - serial-out pin: chain data or flash select
`default_nettype none
module cfg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  assign o_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  assign o_data = mem_q[rd_q];
  // pointers wrap at depth, so any depth works
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (i_clk_en) begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // storage has no reset, empty slots are never read
  always_ff @(posedge i_clk) begin
    if (i_clk_en && push) begin
      mem_q[wr_q] <= i_data;
    end
  end
endmodule : cfg_fifo

module config_port_pin_control #(
  parameter int LOAD_BYTES = cfg_pkg::LOAD_BYTES,
  parameter int CLEAR_CYCLES = cfg_pkg::CLEAR_CYCLES
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  // configuration control pins
  input wire logic [2:0] i_mode,
  input wire logic i_program_request_n,
  input wire logic i_config_ready_n,
  output logic o_config_ready_n,
  output logic o_config_ready_n_oe,
  input wire logic i_done,
  output logic o_done,
  output logic o_done_oe,
  // configuration port pins
  input wire logic i_slave_config_clock,
  output logic o_master_clock,
  output logic o_master_serial_data_out,
  input wire logic i_slave_port_select,
  output logic o_slave_port_select,
  output logic o_slave_port_select_oe,
  input wire logic i_second_parallel_select,
  input wire logic i_parallel_write_strobe,
  output logic o_chain_select_out,
  input wire logic [7:0] i_parallel_data,
  input wire logic i_serial_data_in,
  input wire logic i_flash_data_in,
  // boundary-scan pins
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  // configuration data toward the fabric
  output logic [7:0] o_cfg_data,
  output logic o_cfg_valid,
  input wire logic i_cfg_ready,
  // status
  output logic [2:0] o_mode,
  output logic [1:0] o_port_lock,
  output logic o_overrun,
  output logic o_config_done
);
  localparam int CW = $clog2(CLEAR_CYCLES + 1);
  localparam int BW = $clog2(LOAD_BYTES + 1);
  localparam int MW = $clog2(cfg_pkg::MCLK_HALF_CYCLES + 1);
  localparam int NS = 14;

  logic rst_q1, rst_n;
  logic [NS-1:0] s1_q, s2_q, s3_q;
  logic [2:0] mode_s1_q, mode_s2_q, mode_q;
  logic prog_n, ready_in, ready_rise, sclk_rise, tck_rise, tck_fall;
  logic csn_s, cs1_s, wrn_s, si_s, fdi_s, tms_s, tdi_s;
  logic [7:0] par_s1_q, par_s2_q;
  cfg_pkg::cfg_state_e st_q;
  cfg_pkg::tap_state_e tap_q;
  logic [CW-1:0] clr_q;
  logic [BW-1:0] drain_q;
  logic [1:0] lock_q;
  logic [7:0] sh_q, ir_q, ir_sh_q, dr_q;
  logic [2:0] bit_q, jbit_q;
  logic bypass_q, tdo_q, chain_q, ovr_q, mclk_q;
  logic [MW-1:0] div_q;
  logic [5:0] hdr_cnt_q;
  logic [31:0] hdr_q;
  logic master, loading, mclk_run, mclk_rise, mclk_fall;
  logic bit_v, bit_d, pin_byte_v, jtag_byte_v, byte_v;
  logic [7:0] pin_byte, byte_d;
  logic fifo_ready, fifo_valid, drain;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else if (i_clk_en) begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // pin synchronisers; third stage only feeds edge detection
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 14'h23EF;
      s2_q <= 14'h23EF;
      s3_q <= 14'h23EF;
      mode_s1_q <= 3'h0;
      mode_s2_q <= 3'h0;
      par_s1_q <= 8'h00;
      par_s2_q <= 8'h00;
    end else if (i_clk_en) begin
      s1_q <= {i_program_request_n, i_config_ready_n, i_done,
               i_slave_config_clock, i_slave_port_select,
               i_second_parallel_select, i_parallel_write_strobe,
               i_serial_data_in, i_flash_data_in, i_tck, i_tms, i_tdi,
               2'b11};
      s2_q <= s1_q;
      s3_q <= s2_q;
      mode_s1_q <= i_mode;
      mode_s2_q <= mode_s1_q;
      par_s1_q <= i_parallel_data;
      par_s2_q <= par_s1_q;
    end
  end
  assign prog_n = s2_q[13];
  assign ready_in = s2_q[12];
  assign ready_rise = s2_q[12] & ~s3_q[12];
  assign sclk_rise = s2_q[10] & ~s3_q[10];
  assign csn_s = s2_q[9];
  assign cs1_s = s2_q[8];
  assign wrn_s = s2_q[7];
  assign si_s = s2_q[6];
  assign fdi_s = s2_q[5];
  assign tck_rise = s2_q[4] & ~s3_q[4];
  assign tck_fall = ~s2_q[4] & s3_q[4];
  assign tms_s = s2_q[3];
  assign tdi_s = s2_q[2];

  // configuration sequence
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= cfg_pkg::ST_CLEAR;
      clr_q <= '0;
      mode_q <= 3'h0;
    end else if (i_clk_en) begin
      if (!prog_n) begin
        st_q <= cfg_pkg::ST_CLEAR;
        clr_q <= '0;
      end else begin
        case (st_q)
          cfg_pkg::ST_CLEAR: begin
            if (clr_q == CW'(CLEAR_CYCLES)) begin
              st_q <= cfg_pkg::ST_WAIT_READY;
            end else begin
              clr_q <= clr_q + 1'b1;
            end
          end
          cfg_pkg::ST_WAIT_READY: begin
            if (ready_rise) begin
              mode_q <= mode_s2_q;
              st_q <= cfg_pkg::ST_LOAD;
            end
          end
          cfg_pkg::ST_LOAD: begin
            if (drain && drain_q == BW'(LOAD_BYTES - 1)) begin
              st_q <= cfg_pkg::ST_DONE;
            end
          end
          cfg_pkg::ST_DONE: st_q <= cfg_pkg::ST_DONE;
          default: st_q <= cfg_pkg::ST_CLEAR;
        endcase
      end
    end
  end
  assign loading = (st_q == cfg_pkg::ST_LOAD);
  // open drain: drive low while clearing, release when ready
  assign o_config_ready_n = 1'b0;
  assign o_config_ready_n_oe = (st_q == cfg_pkg::ST_CLEAR);
  assign o_done = 1'b0;
  assign o_done_oe = (st_q != cfg_pkg::ST_DONE);
  assign o_config_done = (st_q == cfg_pkg::ST_DONE) & s2_q[11];
  assign o_mode = mode_q;

  // master clock divider, frozen when the buffer is full
  assign master = (mode_q == cfg_pkg::MODE_MASTER_SPI) |
                  (mode_q == cfg_pkg::MODE_BURST_FLASH);
  assign mclk_run = loading & master & fifo_ready &
                    (lock_q != cfg_pkg::PORT_JTAG);
  assign mclk_rise = mclk_run & ~mclk_q &
                     (div_q == MW'(cfg_pkg::MCLK_HALF_CYCLES - 1));
  assign mclk_fall = mclk_run & mclk_q &
                     (div_q == MW'(cfg_pkg::MCLK_HALF_CYCLES - 1));
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      mclk_q <= 1'b0;
    end else if (i_clk_en) begin
      if (!mclk_run) begin
        div_q <= '0;
        if (!loading) begin
          mclk_q <= 1'b0;
        end
      end else if (div_q == MW'(cfg_pkg::MCLK_HALF_CYCLES - 1)) begin
        div_q <= '0;
        mclk_q <= ~mclk_q;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end
  assign o_master_clock = mclk_q;

  // flash read header, shifted out on falling master clock
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_q <= cfg_pkg::FLASH_READ_HDR;
      hdr_cnt_q <= 6'h00;
    end else if (i_clk_en) begin
      if (!loading) begin
        hdr_q <= cfg_pkg::FLASH_READ_HDR;
        hdr_cnt_q <= 6'h00;
      end else if (mclk_rise && hdr_cnt_q != cfg_pkg::FLASH_HDR_BITS) begin
        hdr_cnt_q <= hdr_cnt_q + 1'b1;
      end else if (mclk_fall) begin
        hdr_q <= {hdr_q[30:0], 1'b0};
      end
    end
  end

  // serial bit sources, msb first
  always_comb begin
    bit_v = 1'b0;
    bit_d = si_s;
    pin_byte_v = 1'b0;
    pin_byte = par_s2_q;
    case (mode_q)
      cfg_pkg::MODE_SLAVE_SPI: bit_v = sclk_rise & ~csn_s & cs1_s;
      cfg_pkg::MODE_SLAVE_SERIAL: bit_v = sclk_rise;
      cfg_pkg::MODE_MASTER_SPI: begin
        bit_v = mclk_rise & (hdr_cnt_q == cfg_pkg::FLASH_HDR_BITS);
        bit_d = fdi_s;
      end
      cfg_pkg::MODE_PARALLEL: begin
        pin_byte_v = sclk_rise & ~csn_s & ~cs1_s & ~wrn_s;
      end
      cfg_pkg::MODE_BURST_FLASH: pin_byte_v = mclk_rise;
      default: bit_v = 1'b0;
    endcase
    if (bit_v && bit_q == 3'h7) begin
      pin_byte_v = 1'b1;
      pin_byte = {sh_q[6:0], bit_d};
    end
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 8'h00;
      bit_q <= 3'h0;
    end else if (i_clk_en) begin
      if (!loading) begin
        bit_q <= 3'h0;
      end else if (bit_v) begin
        sh_q <= {sh_q[6:0], bit_d};
        bit_q <= bit_q + 1'b1;
      end
    end
  end

  // boundary-scan controller, next state on tck rise
  function automatic cfg_pkg::tap_state_e tap_next(
    input cfg_pkg::tap_state_e s, input logic m);
    case (s)
      cfg_pkg::TAP_RESET: tap_next = m ? cfg_pkg::TAP_RESET : cfg_pkg::TAP_IDLE;
      cfg_pkg::TAP_IDLE: tap_next = m ? cfg_pkg::TAP_SEL_DR : cfg_pkg::TAP_IDLE;
      cfg_pkg::TAP_SEL_DR: tap_next = m ? cfg_pkg::TAP_SEL_IR : cfg_pkg::TAP_CAP_DR;
      cfg_pkg::TAP_CAP_DR, cfg_pkg::TAP_SH_DR:
        tap_next = m ? cfg_pkg::TAP_EX1_DR : cfg_pkg::TAP_SH_DR;
      cfg_pkg::TAP_EX1_DR: tap_next = m ? cfg_pkg::TAP_UP_DR : cfg_pkg::TAP_PA_DR;
      cfg_pkg::TAP_PA_DR: tap_next = m ? cfg_pkg::TAP_EX2_DR : cfg_pkg::TAP_PA_DR;
      cfg_pkg::TAP_EX2_DR: tap_next = m ? cfg_pkg::TAP_UP_DR : cfg_pkg::TAP_SH_DR;
      cfg_pkg::TAP_SEL_IR: tap_next = m ? cfg_pkg::TAP_RESET : cfg_pkg::TAP_CAP_IR;
      cfg_pkg::TAP_CAP_IR, cfg_pkg::TAP_SH_IR:
        tap_next = m ? cfg_pkg::TAP_EX1_IR : cfg_pkg::TAP_SH_IR;
      cfg_pkg::TAP_EX1_IR: tap_next = m ? cfg_pkg::TAP_UP_IR : cfg_pkg::TAP_PA_IR;
      cfg_pkg::TAP_PA_IR: tap_next = m ? cfg_pkg::TAP_EX2_IR : cfg_pkg::TAP_PA_IR;
      cfg_pkg::TAP_EX2_IR: tap_next = m ? cfg_pkg::TAP_UP_IR : cfg_pkg::TAP_SH_IR;
      default: tap_next = m ? cfg_pkg::TAP_SEL_DR : cfg_pkg::TAP_IDLE;
    endcase
  endfunction : tap_next

  // instruction and data registers, lsb first
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_q <= cfg_pkg::TAP_RESET;
      ir_q <= cfg_pkg::IR_BYPASS;
      ir_sh_q <= 8'h00;
      dr_q <= 8'h00;
      jbit_q <= 3'h0;
      bypass_q <= 1'b0;
    end else if (i_clk_en && tck_rise) begin
      tap_q <= tap_next(tap_q, tms_s);
      case (tap_q)
        cfg_pkg::TAP_RESET: ir_q <= cfg_pkg::IR_BYPASS;
        cfg_pkg::TAP_CAP_IR: ir_sh_q <= cfg_pkg::IR_CAPTURE;
        cfg_pkg::TAP_SH_IR: ir_sh_q <= {tdi_s, ir_sh_q[7:1]};
        cfg_pkg::TAP_UP_IR: ir_q <= ir_sh_q;
        cfg_pkg::TAP_CAP_DR: begin
          jbit_q <= 3'h0;
          bypass_q <= 1'b0;
        end
        cfg_pkg::TAP_SH_DR: begin
          dr_q <= {tdi_s, dr_q[7:1]};
          jbit_q <= jbit_q + 1'b1;
          bypass_q <= tdi_s;
        end
        default: bypass_q <= bypass_q;
      endcase
    end
  end
  // a scan byte counts only under the load command
  assign jtag_byte_v = tck_rise & (tap_q == cfg_pkg::TAP_SH_DR) &
                       (jbit_q == 3'h7) &
                       (ir_q == cfg_pkg::IR_CFG_LOAD);

  // scan output changes on tck fall
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_q <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (i_clk_en && tck_fall) begin
      o_tdo_oe <= (tap_q == cfg_pkg::TAP_SH_IR) |
                  (tap_q == cfg_pkg::TAP_SH_DR);
      if (tap_q == cfg_pkg::TAP_SH_IR) begin
        tdo_q <= ir_sh_q[0];
      end else if (ir_q == cfg_pkg::IR_CFG_LOAD) begin
        tdo_q <= dr_q[0];
      end else begin
        tdo_q <= bypass_q;
      end
    end
  end
  assign o_tdo = tdo_q;

  // port arbitration; lock survives program requests
  always_comb begin
    byte_v = 1'b0;
    byte_d = pin_byte;
    if (loading && jtag_byte_v && lock_q != cfg_pkg::PORT_PINS) begin
      byte_v = 1'b1;
      byte_d = {tdi_s, dr_q[7:1]};
    end else if (loading && pin_byte_v && lock_q != cfg_pkg::PORT_JTAG) begin
      byte_v = 1'b1;
    end
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= cfg_pkg::PORT_NONE;
      ovr_q <= 1'b0;
    end else if (i_clk_en) begin
      if (byte_v && lock_q == cfg_pkg::PORT_NONE) begin
        lock_q <= (loading && jtag_byte_v) ? cfg_pkg::PORT_JTAG
                                           : cfg_pkg::PORT_PINS;
      end
      // slave sources cannot be stalled, so a full buffer loses data
      if (byte_v && !fifo_ready) begin
        ovr_q <= 1'b1;
      end else if (st_q == cfg_pkg::ST_CLEAR) begin
        ovr_q <= 1'b0;
      end
    end
  end
  assign o_port_lock = lock_q;
  assign o_overrun = ovr_q;

  cfg_fifo #(
    .WIDTH(8),
    .DEPTH(cfg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_clk_en(i_clk_en),
    .i_valid(byte_v),
    .o_ready(fifo_ready),
    .i_data(byte_d),
    .o_valid(fifo_valid),
    .i_ready(i_cfg_ready),
    .o_data(o_cfg_data)
  );
  assign o_cfg_valid = fifo_valid;
  assign drain = fifo_valid & i_cfg_ready;

  // drained byte count ends the load
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      drain_q <= '0;
    end else if (i_clk_en) begin
      if (!loading) begin
        drain_q <= '0;
      end else if (drain) begin
        drain_q <= drain_q + 1'b1;
      end
    end
  end

  // shared pins: busy or serial out, select or flash enable, chain out
  assign o_master_serial_data_out =
    (mode_q == cfg_pkg::MODE_PARALLEL) ? ~fifo_ready : hdr_q[31];
  assign o_slave_port_select = 1'b0;
  assign o_slave_port_select_oe = loading &
    (mode_q == cfg_pkg::MODE_BURST_FLASH);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_q <= 1'b1;
    end else if (i_clk_en) begin
      if (mode_q == cfg_pkg::MODE_MASTER_SPI) begin
        chain_q <= ~loading;
      end else if (mode_q == cfg_pkg::MODE_SLAVE_SERIAL &&
                   st_q == cfg_pkg::ST_DONE) begin
        chain_q <= si_s;
      end else begin
        chain_q <= 1'b1;
      end
    end
  end
  assign o_chain_select_out = chain_q;
endmodule : config_port_pin_control
`default_nettype wire

// ### sim/config_port_pin_control_props.sv
`default_nettype none
module cfg_pin_props #(
  parameter int CLEAR_CYCLES = 5
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // control pins
  input wire logic i_program_request_n,
  input wire logic i_config_ready_n,
  input wire logic o_config_ready_n_oe,
  input wire logic i_done,
  input wire logic o_done_oe,
  // port pins
  input wire logic o_master_clock,
  input wire logic o_slave_port_select_oe,
  input wire logic o_chain_select_out,
  // fabric side and status
  input wire logic [7:0] o_cfg_data,
  input wire logic o_cfg_valid,
  input wire logic i_cfg_ready,
  input wire logic [2:0] o_mode,
  input wire logic [1:0] o_port_lock,
  input wire logic o_config_done
);
  int unsigned hi_cnt_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // length of the current low stretch on the ready pin
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hi_cnt_q <= 0;
    end else if (o_config_ready_n_oe) begin
      hi_cnt_q <= hi_cnt_q + 1;
    end else begin
      hi_cnt_q <= 0;
    end
  end
  mode_capture_a: assert property (
    $changed(o_mode) |-> i_config_ready_n && !o_config_ready_n_oe)
    else $error("mode changed away from the ready edge");
  program_restart_a: assert property (
    $fell(i_program_request_n) |-> ##[1:6] o_config_ready_n_oe)
    else $error("program request did not restart");
  clear_length_a: assert property (
    $fell(o_config_ready_n_oe) |-> hi_cnt_q >= CLEAR_CYCLES + 1)
    else $error("ready pin released too early");
  done_pin_a: assert property (
    o_config_done |-> !o_done_oe && i_done)
    else $error("done reported while done pin held");
  done_in_clear_a: assert property (
    o_config_ready_n_oe |-> o_done_oe)
    else $error("done pin released during clear");
  lock_held_a: assert property (
    o_port_lock != cfg_pkg::PORT_NONE |=> $stable(o_port_lock))
    else $error("port lock changed");
  master_clock_mode_a: assert property (
    $rose(o_master_clock) |-> o_mode == cfg_pkg::MODE_MASTER_SPI ||
      o_mode == cfg_pkg::MODE_BURST_FLASH)
    else $error("master clock outside master modes");
  flash_select_a: assert property (
    !o_chain_select_out |-> o_mode == cfg_pkg::MODE_MASTER_SPI ||
      o_mode == cfg_pkg::MODE_SLAVE_SERIAL)
    else $error("serial out pin low in wrong mode");
  flash_enable_a: assert property (
    o_slave_port_select_oe |-> o_mode == cfg_pkg::MODE_BURST_FLASH)
    else $error("select pin driven outside burst mode");
  stream_hold_a: assert property (
    o_cfg_valid && !i_cfg_ready && i_program_request_n |=>
      o_cfg_valid && $stable(o_cfg_data))
    else $error("stalled byte dropped or changed");
  // main scenarios reached
  cover property ($rose(o_config_done));
  cover property (o_cfg_valid && i_cfg_ready);
  cover property ($rose(o_master_clock));
endmodule : cfg_pin_props

bind config_port_pin_control cfg_pin_props #(
  .CLEAR_CYCLES(CLEAR_CYCLES)
) props_u (
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .i_program_request_n(i_program_request_n),
  .i_config_ready_n(i_config_ready_n),
  .o_config_ready_n_oe(o_config_ready_n_oe),
  .i_done(i_done),
  .o_done_oe(o_done_oe),
  .o_master_clock(o_master_clock),
  .o_slave_port_select_oe(o_slave_port_select_oe),
  .o_chain_select_out(o_chain_select_out),
  .o_cfg_data(o_cfg_data),
  .o_cfg_valid(o_cfg_valid),
  .i_cfg_ready(i_cfg_ready),
  .o_mode(o_mode),
  .o_port_lock(o_port_lock),
  .o_config_done(o_config_done)
);
`default_nettype wire

// ### sim/cfg_host_model.sv
`default_nettype none
module cfg_host_model (
  // pins driven toward the device
  output logic o_prog_n,
  output logic o_sclk,
  output logic o_sel,
  output logic o_run,
  output logic o_sdata,
  output logic o_wr_n,
  output logic [7:0] o_pdata,
  // pin seen from the device
  input wire logic i_ready_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: clock still, deselected, not paused
  initial begin
    o_prog_n = 1'b1;
    o_sclk = 1'b0;
    o_sel = 1'b1;
    o_run = 1'b1;
    o_sdata = 1'b0;
    o_wr_n = 1'b1;
    o_pdata = 8'h00;
  end
  // one link clock period of 125 ns
  task automatic clk_pulse;
    #62.5 o_sclk = 1'b1;
    #62.5 o_sclk = 1'b0;
  endtask : clk_pulse
  // one byte, msb first; a pause carries a wrong bit that must be ignored
  task automatic send_byte(input logic [7:0] b, input bit pause);
    #1 o_sel = 1'b0;
    #62.5;
    for (int i = 7; i >= 0; i--) begin
      if (pause && i == 3) begin
        o_run = 1'b0;
        o_sdata = ~b[i];
        clk_pulse();
        o_run = 1'b1;
      end
      o_sdata = b[i];
      clk_pulse();
    end
    o_sel = 1'b1;
    // released line shows no stale bit
    o_sdata = ~o_sdata;
    #61.5;
  endtask : send_byte
  // one parallel byte: both selects and the write strobe low
  task automatic par_byte(input logic [7:0] b);
    #1 o_sel = 1'b0;
    o_run = 1'b0;
    o_wr_n = 1'b0;
    o_pdata = b;
    clk_pulse();
    o_wr_n = 1'b1;
    o_sel = 1'b1;
    o_run = 1'b1;
    #59;
  endtask : par_byte
  // restart request, then no new one until ready pin is high again
  task automatic program_pulse;
    #1 o_prog_n = 1'b0;
    #200 o_prog_n = 1'b1;
    for (int i = 0; i < 100 && !i_ready_pin; i++) #10;
  endtask : program_pulse
endmodule : cfg_host_model
`default_nettype wire

// ### sim/test_config_port_pin_control.sv
`default_nettype none
module test_config_port_pin_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, tck, tms, fab_rdy;
  logic [2:0] mode, mode_o;
  logic ready_o, ready_oe, done_o, done_oe, mclk, sdo, sel_o, sel_oe;
  logic chain, tdo_oe, cfg_valid, overrun, cfg_done;
  logic [7:0] cfg_data;
  logic [1:0] lock;
  logic prog_n, sclk, host_sel, run, sdata;
  logic ready_pin, done_pin, sel_pin;
  logic wr_n, tdi, tdo, clk_en;
  logic [7:0] pdata;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  // open-drain pins with pull-ups; select pin falls back to the host drive
  assign ready_pin = ready_oe ? ready_o : 1'b1;
  assign done_pin = done_oe ? done_o : 1'b1;
  assign sel_pin = sel_oe ? sel_o : host_sel;
  cfg_host_model host_u (
    .o_prog_n(prog_n),
    .o_sclk(sclk),
    .o_sel(host_sel),
    .o_run(run),
    .o_sdata(sdata),
    .o_wr_n(wr_n),
    .o_pdata(pdata),
    .i_ready_pin(ready_pin)
  );
  // short counts keep the run brief
  config_port_pin_control #(
    .LOAD_BYTES(4),
    .CLEAR_CYCLES(5)
  ) dut_u (
    .i_clk(clk),
    .i_arst_n(arst_n),
    .i_clk_en(clk_en),
    .i_mode(mode),
    .i_program_request_n(prog_n),
    .i_config_ready_n(ready_pin),
    .o_config_ready_n(ready_o),
    .o_config_ready_n_oe(ready_oe),
    .i_done(done_pin),
    .o_done(done_o),
    .o_done_oe(done_oe),
    .i_slave_config_clock(sclk),
    .o_master_clock(mclk),
    .o_master_serial_data_out(sdo),
    .i_slave_port_select(sel_pin),
    .o_slave_port_select(sel_o),
    .o_slave_port_select_oe(sel_oe),
    .i_second_parallel_select(run),
    .i_parallel_write_strobe(wr_n),
    .o_chain_select_out(chain),
    .i_parallel_data(pdata),
    .i_serial_data_in(sdata),
    .i_flash_data_in(1'b1),
    .i_tck(tck),
    .i_tms(tms),
    .i_tdi(tdi),
    .o_tdo(tdo),
    .o_tdo_oe(tdo_oe),
    .o_cfg_data(cfg_data),
    .o_cfg_valid(cfg_valid),
    .i_cfg_ready(fab_rdy),
    .o_mode(mode_o),
    .o_port_lock(lock),
    .o_overrun(overrun),
    .o_config_done(cfg_done)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // hold-state checks, release, then mode pins moved after capture
  task automatic t_reset;
    repeat (4) @(posedge clk);
    chk(ready_oe, 1'b1);
    chk(done_oe, 1'b1);
    chk(lock, cfg_pkg::PORT_NONE);
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 60 && ready_oe !== 1'b0; i++) @(posedge clk);
    chk(ready_oe, 1'b0);
    repeat (10) @(posedge clk);
    mode <= cfg_pkg::MODE_MASTER_SPI;
    repeat (10) @(posedge clk);
    chk(mode_o, cfg_pkg::MODE_SLAVE_SPI);
    $display("test reset done");
  endtask : t_reset
  // fabric stalls: fifo fills, fifth byte refused, then drain in order
  task automatic t_load;
    logic [7:0] exp [5] = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'hFF};
    for (int k = 0; k < 5; k++) host_u.send_byte(exp[k], k == 1);
    repeat (10) @(posedge clk);
    chk(overrun, 1'b1);
    chk(lock, cfg_pkg::PORT_PINS);
    chk(done_oe, 1'b1);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      chk(cfg_valid, 1'b1);
      chk(cfg_data, exp[k]);
      fab_rdy <= 1'b1;
      @(posedge clk);
      fab_rdy <= 1'b0;
      repeat (3) @(posedge clk);
    end
    for (int i = 0; i < 40 && cfg_done !== 1'b1; i++) @(posedge clk);
    chk(cfg_done, 1'b1);
    chk(done_oe, 1'b0);
    chk(cfg_valid, 1'b0);
    $display("test slave load done");
  endtask : t_load
  // restart into master mode; lock survives the restart
  task automatic t_reprogram;
    host_u.program_pulse();
    repeat (10) @(posedge clk);
    chk(mode_o, cfg_pkg::MODE_MASTER_SPI);
    chk(lock, cfg_pkg::PORT_PINS);
    chk(done_oe, 1'b1);
    for (int i = 0; i < 40 && mclk !== 1'b1; i++) @(posedge clk);
    chk(mclk, 1'b1);
    clk_en <= 1'b0;
    repeat (21) @(posedge clk);
    chk(mclk, 1'b1);
    clk_en <= 1'b1;
    chk(chain, 1'b0);
    chk(sdo, 1'b0);
    $display("test master restart done");
  endtask : t_reprogram
  // one scan clock, 40 ns high and 80 ns low
  task automatic tck_bit(input logic t);
    tms <= t;
    repeat (8) @(posedge clk);
    tck <= 1'b1;
    repeat (8) @(posedge clk);
    tck <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : tck_bit
  // reset the scan machine, walk to shift, then leave it
  task automatic t_scan;
    for (int i = 0; i < 5; i++) tck_bit(1'b1);
    tck_bit(1'b0);
    tck_bit(1'b1);
    tck_bit(1'b0);
    tck_bit(1'b0);
    chk(tdo_oe, 1'b1);
    chk(tdo, 1'b0);
    tck_bit(1'b1);
    chk(tdo_oe, 1'b0);
    chk(tdo, 1'b1);
    $display("test scan done");
  endtask : t_scan
  // parallel restart after master ends; busy once the buffer is full
  task automatic t_parallel;
    fab_rdy <= 1'b1;
    for (int i = 0; i < 600 && cfg_done !== 1'b1; i++) @(posedge clk);
    chk(cfg_done, 1'b1);
    fab_rdy <= 1'b0;
    mode <= cfg_pkg::MODE_PARALLEL;
    host_u.program_pulse();
    repeat (10) @(posedge clk);
    chk(mode_o, cfg_pkg::MODE_PARALLEL);
    for (int k = 0; k < 4; k++) host_u.par_byte(8'h5A ^ 8'(k));
    repeat (10) @(posedge clk);
    chk(sdo, 1'b1);
    chk(cfg_data, 8'h5A);
    $display("test parallel done");
  endtask : t_parallel
  // clock source
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    arst_n = 1'b0;
    mode = cfg_pkg::MODE_SLAVE_SPI;
    tck = 1'b0;
    tms = 1'b1;
    fab_rdy = 1'b0;
    clk_en = 1'b1;
    tdi = 1'b1;
    t_reset();
    t_load();
    t_reprogram();
    t_scan();
    t_parallel();
    print_verdict();
  end
endmodule : test_config_port_pin_control
`default_nettype wire
